/* File: logic/xlat_result_pkg.sv */
// Constants for the translation result register block.
// Assumes an APB master on sys_clk and a translation engine on the same clock.
//
// Overview of operation
// RL1 - Short success: PA[31:12] into bits 31:12
// RL2 - Short success: bit 11 reads zero
// RL3 - Bit 10 flags not outer shareable
// RL4 - Bit 9 secure-bank nonsecure attribute, else zero
// RL5 - Short success: bit 7 flags shareable
// RL6 - Inner attribute code in bits 6:4
// RL7 - Outer attribute code in bits 3:2
// RL8 - Bit 1 flags supersection
// RL9 - Supersection: PA[39:32] into bits 23:16, zeros below
// RL10 - Success layouts clear bit 0
// RL11 - Long success: attribute byte in bits 63:56
// RL12 - Long PA bits 47:12, unimplemented read zero
// RL13 - Long success: bit 11 reads one
// RL14 - Fault: read-only format field, 0b11 as wide; code reports wide as 0b10
// RL15 - Software avoids reconfiguring with faults pending
// RL16 - Fault bit 7 address size fault
// RL17 - Fault bit 6 lookaside lock fault
// RL18 - Fault bit 5 multiple match, optional
// RL19 - Fault bit 4 external walk fault, optional
// RL20 - Fault bits 3,2,1 permission, access, translation
// RL21 - Abort sets bit 0
// RL22 - 64-bit read/write result register
// RL23 - Layout by scheme and outcome, atomic write
package xlat_result_pkg;
  // Register byte offsets
  localparam logic [7:0] RESULT_LO_OFFSET  = 8'h00;
  localparam logic [7:0] RESULT_HI_OFFSET  = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET     = 8'h0c;
  localparam logic [63:0] RESULT_RESET     = 64'h0;
  localparam logic [1:0]  CONTROL_RESET    = 2'h0;
  // Control fields
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_EXT_BIT  = 1;
  // Result fields
  localparam int FAULT_BIT      = 0;
  localparam int SUPER_BIT      = 1;
  localparam int OUTER_LSB      = 2;
  localparam int INNER_LSB      = 4;
  localparam int SHARE_BIT      = 7;
  localparam int SHFIELD_LSB    = 7;
  localparam int NSEC_BIT       = 9;
  localparam int NOS_BIT        = 10;
  localparam int FIXED_BIT      = 11;
  localparam int PA_LSB         = 12;
  localparam int MEMORY_ATTR_BYTE_LSB      = 56;
  localparam int FMT_LSB        = 8;
  localparam int FAULT_CAUSE_LSB = 1;
  // Fault-layout format codes
  localparam logic [1:0] FMT_SHORT = 2'h0;
  localparam logic [1:0] FMT_LONG  = 2'h1;
  localparam logic [1:0] FMT_WIDE  = 2'h2;
  // Fault cause vector positions (vector bit i lands on result bit i+1)
  localparam int CAUSE_TF  = 0;
  localparam int CAUSE_AFF = 1;
  localparam int CAUSE_PF  = 2;
  localparam int CAUSE_EF  = 3;
  localparam int CAUSE_MC  = 4;
  localparam int CAUSE_LK  = 5;
  localparam int CAUSE_ASF = 6;
  typedef enum logic [1:0] {SCHEME_SHORT, SCHEME_LONG, SCHEME_WIDE} scheme_t;
endpackage

/* File: logic/xlat_short_layout.sv */
// Short-descriptor success layout of the translation result.
// Assumes inputs already valid for the completing operation.
`timescale 1ns/10ps
module xlat_short_layout #(
  parameter bit SHARE_DISTINCT = 1'b1,
  parameter bit TWO_SECURITY   = 1'b1
) (
  input  wire logic [39:12] paIn,
  input  wire logic         superSection,
  input  wire logic         notOuterShare,
  input  wire logic         nonSecAttr,
  input  wire logic         secureBank,
  input  wire logic         shareable,
  input  wire logic [2:0]   innerAttr,
  input  wire logic [1:0]   outerAttr,
  output logic      [63:0]  layout
);
  always_comb
  begin
    layout = 64'h0;
    if (superSection)
    begin
      layout[31:24] = paIn[31:24];  // RL9
      layout[23:16] = paIn[39:32];  // RL9
      layout[15:12] = 4'h0;         // RL9
    end
    else
    begin
      layout[31:12] = paIn[31:12];  // RL1
    end
    layout[xlat_result_pkg::FIXED_BIT] = 1'b0;                              // RL2
    layout[xlat_result_pkg::NOS_BIT] = SHARE_DISTINCT & notOuterShare;      // RL3
    layout[xlat_result_pkg::NSEC_BIT] = TWO_SECURITY & secureBank & nonSecAttr;  // RL4
    layout[xlat_result_pkg::SHARE_BIT] = shareable;                          // RL5
    layout[xlat_result_pkg::INNER_LSB +: 3] = innerAttr;                     // RL6
    layout[xlat_result_pkg::OUTER_LSB +: 2] = outerAttr;                     // RL7
    layout[xlat_result_pkg::SUPER_BIT] = superSection;                       // RL8
    layout[xlat_result_pkg::FAULT_BIT] = 1'b0;                               // RL10
  end
endmodule // xlat_short_layout

/* File: logic/xlat_long_layout.sv */
// Long-descriptor and wide-scheme success layout of the translation result.
// Assumes PA_BITS is the larger of input and output address sizes.
`timescale 1ns/10ps
module xlat_long_layout #(
  parameter int PA_BITS      = 48,
  parameter bit TWO_SECURITY = 1'b1
) (
  input  wire logic [47:12] paIn,
  input  wire logic [7:0]   memAttrByte,
  input  wire logic [1:0]   shareField,
  input  wire logic         nonSecAttr,
  input  wire logic         secureBank,
  output logic      [63:0]  layout
);
  logic [47:12] paMask;
  always_comb
  begin
    paMask = '0;
    for (int i = 12; i < 48; i++)
    begin
      paMask[i] = (i < PA_BITS);  // RL12
    end
    layout = 64'h0;
    layout[xlat_result_pkg::MEMORY_ATTR_BYTE_LSB +: 8] = memAttrByte;  // RL11
    layout[47:12] = paIn & paMask;                          // RL12
    layout[xlat_result_pkg::FIXED_BIT] = 1'b1;              // RL13
    layout[xlat_result_pkg::NSEC_BIT] = TWO_SECURITY & secureBank & nonSecAttr;  // RL4
    layout[xlat_result_pkg::SHFIELD_LSB +: 2] = shareField;
    layout[xlat_result_pkg::FAULT_BIT] = 1'b0;              // RL10
  end
endmodule // xlat_long_layout

/* File: logic/translation_result_top.sv */
// Translation result register with APB access and completion capture.
// Assumes the translation engine drives its completion ports on sys_clk.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module translation_result_top #(
  parameter int PA_BITS        = 48,
  parameter bit SHARE_DISTINCT = 1'b1,
  parameter bit TWO_SECURITY   = 1'b1,
  parameter bit MATCH_DETECT   = 1'b1,
  parameter bit EXT_DETECT     = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        opDone,
  input  wire logic        opFault,
  input  wire logic [47:12] paIn,
  input  wire logic        superSection,
  input  wire logic        notOuterShare,
  input  wire logic        nonSecAttr,
  input  wire logic        secureBank,
  input  wire logic        shareable,
  input  wire logic [2:0]  innerAttr,
  input  wire logic [1:0]  outerAttr,
  input  wire logic [7:0]  memAttrByte,
  input  wire logic [1:0]  shareField,
  input  wire logic        addressSizeFault,
  input  wire logic        tlbLockFault,
  input  wire logic        tlbMultimatchFault,
  input  wire logic        externalWalkFault,
  input  wire logic        permissionFault,
  input  wire logic        accessFlagFault,
  input  wire logic        translationFault,
  output logic      [1:0]  schemeOut,
  output logic             resultValid
);

  if (PA_BITS < 32 || PA_BITS > 48)
  begin : g_bad_pa_bits
    $error("PA_BITS must lie between 32 and 48");
  end

  // ****************************************************************
  // Control register and scheme selection
  // ****************************************************************
  logic [1:0] controlQ;
  logic       wideSel;
  logic       extEffective;
  xlat_result_pkg::scheme_t scheme;
  logic [1:0] fmtCode;

  assign wideSel      = controlQ[xlat_result_pkg::CTRL_WIDE_BIT];
  assign extEffective = wideSel | controlQ[xlat_result_pkg::CTRL_EXT_BIT];

  always_comb
  begin
    if (wideSel)
      scheme = xlat_result_pkg::SCHEME_WIDE;
    else if (extEffective)
      scheme = xlat_result_pkg::SCHEME_LONG;
    else
      scheme = xlat_result_pkg::SCHEME_SHORT;
  end

  // Format code follows the live configuration
  always_comb
  begin
    case (scheme)
      xlat_result_pkg::SCHEME_WIDE:  fmtCode = xlat_result_pkg::FMT_WIDE;   // RL14
      xlat_result_pkg::SCHEME_LONG:  fmtCode = xlat_result_pkg::FMT_LONG;   // RL14
      xlat_result_pkg::SCHEME_SHORT: fmtCode = xlat_result_pkg::FMT_SHORT;  // RL14
      default:                       fmtCode = xlat_result_pkg::FMT_WIDE;
    endcase
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic setupPhase;
  logic accessWrite;
  logic hitLo;
  logic hitHi;
  logic hitCtrl;
  logic hitStat;
  logic mapped;

  assign setupPhase  = psel & ~penable;
  assign accessWrite = psel & penable & pwrite;
  assign hitLo   = (paddr == xlat_result_pkg::RESULT_LO_OFFSET);
  assign hitHi   = (paddr == xlat_result_pkg::RESULT_HI_OFFSET);
  assign hitCtrl = (paddr == xlat_result_pkg::CONTROL_OFFSET);
  assign hitStat = (paddr == xlat_result_pkg::STATUS_OFFSET);
  assign mapped  = hitLo | hitHi | hitCtrl | hitStat;

  // Zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // ****************************************************************
  // Layout builders
  // ****************************************************************
  logic [63:0] shortLayout;
  logic [63:0] longLayout;
  logic [63:0] faultLayout;
  logic [63:0] captureValue;

  xlat_short_layout #(
    .SHARE_DISTINCT (SHARE_DISTINCT),
    .TWO_SECURITY   (TWO_SECURITY)
  ) shortPack (
    .paIn          (paIn[39:12]),
    .superSection  (superSection),
    .notOuterShare (notOuterShare),
    .nonSecAttr    (nonSecAttr),
    .secureBank    (secureBank),
    .shareable     (shareable),
    .innerAttr     (innerAttr),
    .outerAttr     (outerAttr),
    .layout        (shortLayout)
  );

  xlat_long_layout #(
    .PA_BITS      (PA_BITS),
    .TWO_SECURITY (TWO_SECURITY)
  ) longPack (
    .paIn        (paIn),
    .memAttrByte (memAttrByte),
    .shareField  (shareField),
    .nonSecAttr  (nonSecAttr),
    .secureBank  (secureBank),
    .layout      (longLayout)
  );

  always_comb
  begin
    faultLayout = 64'h0;
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_ASF] = addressSizeFault;  // RL16
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_LK]  = tlbLockFault;      // RL17
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_MC]  =
      MATCH_DETECT & tlbMultimatchFault;                                                            // RL18
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_EF]  =
      EXT_DETECT & externalWalkFault;                                                               // RL19
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_PF]  = permissionFault;   // RL20
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_AFF] = accessFlagFault;   // RL20
    faultLayout[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_TF]  = translationFault;  // RL20
    faultLayout[xlat_result_pkg::FAULT_BIT] = 1'b1;                                                 // RL21
  end

  always_comb
  begin
    if (opFault)
      captureValue = faultLayout;  // RL23
    else if (scheme == xlat_result_pkg::SCHEME_SHORT)
      captureValue = shortLayout;  // RL23
    else
      captureValue = longLayout;   // RL23
  end

  // ****************************************************************
  // Software write masks
  // ****************************************************************
  logic [63:0] resultQ;
  logic [63:0] wiMask;
  always_comb
  begin
    wiMask = 64'h0;
    if (resultQ[xlat_result_pkg::FAULT_BIT])
    begin
      wiMask[xlat_result_pkg::FMT_LSB +: 2] = 2'h3;  // RL14
      wiMask[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_MC] = ~MATCH_DETECT;  // RL18
      wiMask[xlat_result_pkg::FAULT_CAUSE_LSB + xlat_result_pkg::CAUSE_EF] = ~EXT_DETECT;    // RL19
    end
    else if (scheme == xlat_result_pkg::SCHEME_SHORT)
    begin
      wiMask[xlat_result_pkg::NOS_BIT]  = ~SHARE_DISTINCT;  // RL3
      wiMask[xlat_result_pkg::NSEC_BIT] = ~TWO_SECURITY;    // RL4
    end
    else
    begin
      for (int i = 12; i < 48; i++)
      begin
        wiMask[i] = (i >= PA_BITS);  // RL12
      end
      wiMask[xlat_result_pkg::NSEC_BIT] = ~TWO_SECURITY;  // RL4
    end
  end

  // ****************************************************************
  // Result register
  // ****************************************************************
  logic [63:0] resultD;
  logic [63:0] swValue;

  always_comb
  begin
    swValue = resultQ;
    if (accessWrite && hitLo)
      swValue[31:0] = merge(resultQ[31:0], pwdata, pstrb);
    if (accessWrite && hitHi)
      swValue[63:32] = merge(resultQ[63:32], pwdata, pstrb);
    swValue = (swValue & ~wiMask) | (resultQ & wiMask);
    // Completion wins over a software write in the same cycle
    if (opDone)
      resultD = captureValue;  // RL23
    else
      resultD = swValue;       // RL22
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      resultQ <= xlat_result_pkg::RESULT_RESET;
    else
      resultQ <= resultD;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      controlQ <= xlat_result_pkg::CONTROL_RESET;
    else if (accessWrite && hitCtrl && pstrb[0])
      controlQ <= pwdata[1:0];
  end

  // Tracks that a completion has been captured since reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      resultValid <= 1'b0;
    else if (opDone)
      resultValid <= 1'b1;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [63:0] resultView;
  logic [31:0] readD;

  always_comb
  begin
    resultView = resultQ;
    if (resultQ[xlat_result_pkg::FAULT_BIT])
      resultView[xlat_result_pkg::FMT_LSB +: 2] = fmtCode;  // RL14
  end

  always_comb
  begin
    readD = 32'h0;
    if (hitLo)
      readD = resultView[31:0];
    else if (hitHi)
      readD = resultView[63:32];
    else if (hitCtrl)
      readD = {30'h0, controlQ};
    else if (hitStat)
      readD = {28'h0, resultQ[xlat_result_pkg::FAULT_BIT], resultValid, fmtCode};
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0;
    else if (setupPhase && !pwrite)
      prdata <= readD;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      schemeOut <= 2'h0;
    else
      schemeOut <= fmtCode;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic shortOk;
  logic longOk;
  assign shortOk = opDone && !opFault && (scheme == xlat_result_pkg::SCHEME_SHORT);
  assign longOk  = opDone && !opFault && (scheme != xlat_result_pkg::SCHEME_SHORT);

  property p_short_pa;
    @(posedge sys_clk) disable iff (!reset_n)
    (shortOk && !superSection) |=> (resultQ[31:12] == $past(paIn[31:12]));
  endproperty
  a_short_pa: assert property (p_short_pa) else $error("short pa not captured");  // RL1

  property p_short_fixed;
    @(posedge sys_clk) disable iff (!reset_n)
    shortOk |=> (resultQ[11] == 1'b0) && (resultQ[0] == 1'b0) && (resultQ[1] == $past(superSection));
  endproperty
  a_short_fixed: assert property (p_short_fixed) else $error("short fixed bits wrong");  // RL2

  property p_short_attr;
    @(posedge sys_clk) disable iff (!reset_n)
    shortOk |=> (resultQ[6:2] == {$past(innerAttr), $past(outerAttr)}) && (resultQ[7] == $past(shareable));
  endproperty
  a_short_attr: assert property (p_short_attr) else $error("short attributes wrong");  // RL6

  property p_super;
    @(posedge sys_clk) disable iff (!reset_n)
    (shortOk && superSection) |=> (resultQ[23:16] == $past(paIn[39:32])) && (resultQ[15:12] == 4'h0);
  endproperty
  a_super: assert property (p_super) else $error("supersection layout wrong");  // RL9

  property p_long;
    @(posedge sys_clk) disable iff (!reset_n)
    longOk |=> (resultQ[11] == 1'b1) && (resultQ[63:56] == $past(memAttrByte)) && (resultQ[55:48] == 8'h0);
  endproperty
  a_long: assert property (p_long) else $error("long layout wrong");  // RL13

  property p_long_unimpl;
    @(posedge sys_clk) disable iff (!reset_n)
    longOk |=> ((resultQ[47:12] >> (PA_BITS - 12)) == 36'h0);
  endproperty
  a_long_unimpl: assert property (p_long_unimpl) else $error("unimplemented pa bits set");  // RL12

  property p_fault;
    @(posedge sys_clk) disable iff (!reset_n)
    (opDone && opFault) |=> resultQ[0] && (resultQ[7] == $past(addressSizeFault))
      && (resultQ[6] == $past(tlbLockFault)) && (resultQ[3:1] ==
      {$past(permissionFault), $past(accessFlagFault), $past(translationFault)});
  endproperty
  a_fault: assert property (p_fault) else $error("fault layout wrong");  // RL21

  property p_fmt;
    @(posedge sys_clk) disable iff (!reset_n)
    (resultQ[0] && wideSel) |-> (resultView[9:8] == 2'h2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format code wrong");  // RL14

  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    (!opDone && !accessWrite) |=> $stable(resultQ);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without cause");  // RL23

endmodule // translation_result_top

/* File: verification/translation_result_tb.sv */
// Self-checking bench for the translation result register block.
// Assumes the block answers APB with zero wait states and captures on opDone.
`timescale 1ns/10ps
module translation_result_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic         sys_clk;
  logic         reset_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         opDone;
  logic         opFault;
  logic [47:12] paIn;
  logic         superSection;
  logic         notOuterShare;
  logic         nonSecAttr;
  logic         secureBank;
  logic         shareable;
  logic [2:0]   innerAttr;
  logic [1:0]   outerAttr;
  logic [7:0]   memAttrByte;
  logic [1:0]   shareField;
  logic [6:0]   causes;
  logic [1:0]   schemeOut;
  logic         resultValid;
  int           errCount;
  int           comparisons;

  translation_result_top DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opDone(opDone), .opFault(opFault), .paIn(paIn),
    .superSection(superSection), .notOuterShare(notOuterShare), .nonSecAttr(nonSecAttr),
    .secureBank(secureBank), .shareable(shareable), .innerAttr(innerAttr), .outerAttr(outerAttr),
    .memAttrByte(memAttrByte), .shareField(shareField), .addressSizeFault(causes[6]),
    .tlbLockFault(causes[5]), .tlbMultimatchFault(causes[4]), .externalWalkFault(causes[3]),
    .permissionFault(causes[2]), .accessFlagFault(causes[1]), .translationFault(causes[0]),
    .schemeOut(schemeOut), .resultValid(resultValid)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      errCount++;
      $display("wrong value at %0t: no pready", $time);
      end_sim();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_op(input logic flt);
    @(posedge sys_clk);
    paIn          <= 36'({$urandom, $urandom});
    superSection  <= 1'($urandom);
    notOuterShare <= 1'($urandom);
    nonSecAttr    <= 1'($urandom);
    secureBank    <= 1'($urandom);
    shareable     <= 1'($urandom);
    memAttrByte   <= 8'($urandom);
    shareField    <= 2'($urandom);
    causes        <= 7'($urandom);
    opFault       <= flt;
    opDone        <= 1'b1;
    @(posedge sys_clk);
    opDone        <= 1'b0;
  endtask

  function automatic logic [1:0] fmt_of(input logic [1:0] ctl);
    return ctl[0] ? 2'h2 : (ctl[1] ? 2'h1 : 2'h0);
  endfunction

  function automatic logic [63:0] expect_res(input logic [1:0] ctl, input logic flt);
    logic [63:0] r;
    r = 64'h0;
    if (flt)
    begin
      r[0]   = 1'b1;
      r[7:1] = causes;
      r[9:8] = fmt_of(ctl);
    end
    else if (fmt_of(ctl) == 2'h0)
    begin
      r[31:12] = superSection ? {paIn[31:24], paIn[39:32], 4'h0} : paIn[31:12];
      r[10]    = notOuterShare;
      r[9]     = secureBank & nonSecAttr;
      r[7]     = shareable;
      r[6:4]   = innerAttr;
      r[3:2]   = outerAttr;
      r[1]     = superSection;
    end
    else
    begin
      r[63:56] = memAttrByte;
      r[47:12] = paIn;
      r[11]    = 1'b1;
      r[9]     = secureBank & nonSecAttr;
      r[8:7]   = shareField;
    end
    return r;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] lo;
    logic [31:0] hi;
    logic        er;
    logic [1:0]  ctl;
    logic        flt;
    logic [63:0] ex;
    errCount = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {opDone, opFault, paIn, superSection, notOuterShare, nonSecAttr, secureBank} = '0;
    {shareable, innerAttr, outerAttr, memAttrByte, shareField, causes} = '0;
    void'($urandom(68));
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;

    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0, 4'hf, lo, er);
      check({er, lo}, 33'h0, "reset value");
    end
    check(resultValid, 1'b0, "valid after reset");
    $display("test done: reset values");

    apb(1'b1, 8'h10, 32'hffffffff, 4'hf, lo, er);
    check(er, 1'b1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0, 4'hf, lo, er);
    check({er, lo}, 33'h100000000, "unmapped read");
    apb(1'b1, xlat_result_pkg::CONTROL_OFFSET, 32'h3, 4'he, lo, er);
    apb(1'b0, xlat_result_pkg::CONTROL_OFFSET, 32'h0, 4'hf, lo, er);
    check(lo, 32'h0, "control after masked or unmapped write");
    $display("test done: refused accesses");

    for (int i = 0; i < 32; i++)
    begin
      ctl = 2'(i >> 3);
      flt = (i % 3 == 2);
      innerAttr <= 3'(i);
      outerAttr <= 2'(i);
      apb(1'b1, xlat_result_pkg::CONTROL_OFFSET, {30'h0, ctl}, 4'hf, lo, er);
      @(posedge sys_clk);
      #1;
      check(schemeOut, fmt_of(ctl), "scheme code");
      do_op(flt);
      ex = expect_res(ctl, flt);
      apb(1'b0, xlat_result_pkg::RESULT_LO_OFFSET, 32'h0, 4'hf, lo, er);
      check(lo, ex[31:0], "result low word");
      apb(1'b0, xlat_result_pkg::RESULT_HI_OFFSET, 32'h0, 4'hf, lo, er);
      check(lo, ex[63:32], "result high word");
      apb(1'b0, xlat_result_pkg::STATUS_OFFSET, 32'h0, 4'hf, lo, er);
      check(lo[3:0], {flt, 1'b1, fmt_of(ctl)}, "status");
      check(resultValid, 1'b1, "valid after completion");
      if (flt)
      begin
        // Format field must ignore the write; control stays put while the fault is pending
        apb(1'b1, xlat_result_pkg::RESULT_LO_OFFSET, {22'h0, ~fmt_of(ctl), causes, 1'b1}, 4'hf, lo, er);
        apb(1'b0, xlat_result_pkg::RESULT_LO_OFFSET, 32'h0, 4'hf, lo, er);
        check(lo[9:0], {fmt_of(ctl), causes, 1'b1}, "fault format read-only");
        // Fault handled before the next reconfiguration
        apb(1'b1, xlat_result_pkg::RESULT_LO_OFFSET, 32'h0, 4'hf, lo, er);
      end
    end
    $display("test done: layouts");

    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, xlat_result_pkg::CONTROL_OFFSET, 32'h1, 4'hf, lo, er);
      do_op(1'b1);
      @(posedge sys_clk);
      causes <= 7'h1 << k;
      opFault <= 1'b1;
      opDone <= 1'b1;
      @(posedge sys_clk);
      opDone <= 1'b0;
      apb(1'b0, xlat_result_pkg::RESULT_LO_OFFSET, 32'h0, 4'hf, lo, er);
      check(lo, {22'h0, 2'h2, 7'h1 << k, 1'b1}, "single fault cause");
      apb(1'b1, xlat_result_pkg::RESULT_LO_OFFSET, 32'h0, 4'hf, lo, er);
    end
    $display("test done: fault causes");
    end_sim();
  end
endmodule // translation_result_tb
